//--- hw/tac_defines.svh
// constants for the two-wire address, clock-rate and time-out block
`ifndef TAC_DEFINES_SVH
`define TAC_DEFINES_SVH
`define TAC_IDX_RATE 8'hbe
`define TAC_IDX_TOC 8'hbf
`define TAC_IDX_ADDR 8'hc1
`define TAC_OFF_RATE 12'h2f8
`define TAC_OFF_TOC 12'h2fc
`define TAC_OFF_ADDR 12'h304
`define TAC_OFF_STAT 12'h308
`define TAC_OFF_IMASK 12'h30c
`define TAC_OFF_CODE 12'h310
`define TAC_RST_RATE 8'h09
`define TAC_RST_TOC 3'h1
`define TAC_RST_ADDR 8'h00
`define TAC_TOC_EN 2
`define TAC_TOC_DIV 1
`define TAC_TOC_FLAG 0
`define TAC_ADDR_GC 0
`define TAC_CODE_IDLE 5'h1f
`define TAC_CODE_OWN_WR 5'h0c
`define TAC_CODE_OWN_RD 5'h15
`define TAC_CODE_GCALL 5'h0e
`define TAC_CODE_TIMEOUT 5'h00
`define TAC_TO_DIV4 2'h3
`define TAC_TO_LAST 14'h3fff
`define TAC_IRQ_EVENT 0
`define TAC_IRQ_TIMEOUT 1
`endif

//--- hw/tac_pkg.sv
// types shared by the two-wire configuration block
package tac_pkg;
  typedef logic [7:0] tac_byte_t;
  typedef logic [4:0] tac_code_t;
  typedef enum logic [1:0] {
    TAC_SL_IDLE = 2'b00,
    TAC_SL_WAIT = 2'b01,
    TAC_SL_ADDRESSED = 2'b10
  } tac_slave_e;
endpackage

//--- hw/tac_rate_gen.sv
// master serial clock enable generator
`timescale 1ns/1ps
module tac_rate_gen
  import tac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  input wire tac_pkg::tac_byte_t divisor,
  output logic scl_tick
);
  import tac_pkg::*;
  logic [9:0] cnt_reg;
  wire [9:0] limit = {divisor, 2'b11};
  wire at_end = (cnt_reg >= limit);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 10'h000;
      scl_tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= (!run || at_end) ? 10'h000 : cnt_reg + 10'h001;
      scl_tick <= run && at_end;
    end
  end
endmodule // tac_rate_gen

//--- hw/tac_timeout.sv
// 14-bit bus time-out counter with prescaler
`timescale 1ns/1ps
`include "tac_defines.svh"
module tac_timeout
  import tac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic enable,
  input wire logic div4,
  input wire logic restart,
  output logic overflow
);
  import tac_pkg::*;
  logic [1:0] pre_reg;
  logic [13:0] cnt_reg;
  wire step = enable && (!div4 || pre_reg == `TAC_TO_DIV4);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_reg <= 2'h0;
      cnt_reg <= 14'h0000;
      overflow <= 1'b0;
    end
    else
    begin
      pre_reg <= enable ? pre_reg + 2'h1 : 2'h0;
      if (!enable || restart)
        cnt_reg <= 14'h0000;
      else if (step)
        cnt_reg <= cnt_reg + 14'h0001;
      overflow <= step && !restart && (cnt_reg == `TAC_TO_LAST);
    end
  end
  to_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enable && !div4 && !restart) |=> cnt_reg == $past(cnt_reg) + 14'h0001)
    else $error("time-out counter missed a full-rate step");
  to_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enable && div4 && !restart && pre_reg != `TAC_TO_DIV4) |=> $stable(cnt_reg))
    else $error("time-out counter stepped between prescale ticks");
  to_quarter_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enable && div4 && !restart && pre_reg == `TAC_TO_DIV4) |=>
    cnt_reg == $past(cnt_reg) + 14'h0001)
    else $error("time-out counter missed a prescaled step");
endmodule // tac_timeout

//--- hw/tac_config.sv
// two-wire controller address match, rate divider and time-out, APB slave
// Behaviour
// - slave compares upper seven bits of first byte against own address
// - own-address match acknowledged and addressed only with acknowledge enable set
// - own address ignored while operating as master
// - general call ignored when disabled; recognised only with acknowledge enable
// - general call enable has no effect in master mode
// - master clock is system clock over four times (divisor plus one)
// - divisor ignored in slave mode; slave follows master rate
// - time-out counter runs only while its enable bit is set
// - time-out counter ticks every clock, or every fourth with divide select
// - counter overflow sets sticky time-out flag until software clears it
// - meaningful states load status code, set event flag and request interrupt when the status bit is unmasked
`timescale 1ns/1ps
`include "tac_defines.svh"
module tac_config
  import tac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic master_mode,
  input wire logic acknowledge_enable,
  input wire logic start_seen,
  input wire logic byte_done,
  input wire tac_pkg::tac_byte_t rx_byte,
  input wire logic bus_activity,
  output logic addr_ack,
  output logic slave_addressed,
  output logic gcall_addressed,
  output logic scl_tick,
  output logic [4:0] bus_state_code,
  output logic serial_event,
  output logic timeout_overflow_flag,
  output logic irq
);
  import tac_pkg::*;
  tac_byte_t bit_rate_divisor_reg;
  logic [2:0] timeout_control_reg;
  tac_byte_t own_slave_address_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  tac_slave_e sl_reg;
  tac_slave_e sl_next;
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire acc_wr = acc && pwrite;
  wire hit_rate = paddr == `TAC_OFF_RATE;
  wire hit_toc = paddr == `TAC_OFF_TOC;
  wire hit_addr = paddr == `TAC_OFF_ADDR;
  wire hit_stat = paddr == `TAC_OFF_STAT;
  wire hit_mask = paddr == `TAC_OFF_IMASK;
  wire hit_code = paddr == `TAC_OFF_CODE;
  wire hit_any = hit_rate || hit_toc || hit_addr || hit_stat || hit_mask || hit_code;
  wire timeout_counter_enable = timeout_control_reg[`TAC_TOC_EN];
  wire general_call_enable = own_slave_address_reg[`TAC_ADDR_GC];
  wire to_ovf;
  // slave address decode, masked off entirely in master mode
  wire first_byte = (sl_reg == TAC_SL_WAIT) && byte_done && !master_mode;
  wire own_match = first_byte && (rx_byte[7:1] == own_slave_address_reg[7:1]);
  wire gc_match = first_byte && (rx_byte == 8'h00) && general_call_enable;
  wire own_take = own_match && acknowledge_enable;
  wire gc_take = gc_match && acknowledge_enable;
  wire take_any = own_take || gc_take;
  wire tac_code_t code_next = gc_take ? `TAC_CODE_GCALL :
    (rx_byte[0] ? `TAC_CODE_OWN_RD : `TAC_CODE_OWN_WR);
  wire clr_wr = acc_wr && hit_stat;
  wire to_clr = acc_wr && hit_toc && !pwdata[`TAC_TOC_FLAG];
  wire [31:0] rd_mux =
    hit_rate ? {24'h000000, bit_rate_divisor_reg} :
    hit_toc ? {29'h00000000, timeout_control_reg} :
    hit_addr ? {24'h000000, own_slave_address_reg} :
    hit_stat ? {30'h00000000, stat_reg} :
    hit_mask ? {30'h00000000, mask_reg} :
    hit_code ? {24'h000000, bus_state_code, 3'h0} : 32'h00000000;

  always_comb
  begin
    sl_next = sl_reg;
    case (sl_reg)
      TAC_SL_IDLE: if (start_seen && !master_mode) sl_next = TAC_SL_WAIT;
      TAC_SL_WAIT:
        if (master_mode) sl_next = TAC_SL_IDLE;
        else if (byte_done) sl_next = take_any ? TAC_SL_ADDRESSED : TAC_SL_IDLE;
      TAC_SL_ADDRESSED:
        if (master_mode) sl_next = TAC_SL_IDLE;
        else if (start_seen) sl_next = TAC_SL_WAIT;
      default: sl_next = TAC_SL_IDLE;
    endcase
  end

  tac_rate_gen u_rate
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(master_mode),
    .divisor(bit_rate_divisor_reg),
    .scl_tick(scl_tick)
  );

  tac_timeout u_to
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(timeout_counter_enable),
    .div4(timeout_control_reg[`TAC_TOC_DIV]),
    .restart(bus_activity),
    .overflow(to_ovf)
  );

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_rate_divisor_reg <= `TAC_RST_RATE;
      own_slave_address_reg <= `TAC_RST_ADDR;
      mask_reg <= 2'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !((paddr[1:0] == 2'h0) && hit_any);
      prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
      if (acc_wr && hit_rate)
        bit_rate_divisor_reg <= pwdata[7:0];
      if (acc_wr && hit_addr)
        own_slave_address_reg <= pwdata[7:0];
      if (acc_wr && hit_mask)
        mask_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      timeout_control_reg <= `TAC_RST_TOC;
    else
    begin
      if (acc_wr && hit_toc)
        timeout_control_reg[2:1] <= pwdata[2:1];
      if (to_ovf)
        timeout_control_reg[`TAC_TOC_FLAG] <= 1'b1;
      else if (to_clr)
        timeout_control_reg[`TAC_TOC_FLAG] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sl_reg <= TAC_SL_IDLE;
      addr_ack <= 1'b0;
      slave_addressed <= 1'b0;
      gcall_addressed <= 1'b0;
      bus_state_code <= `TAC_CODE_IDLE;
      stat_reg <= 2'h0;
      serial_event <= 1'b0;
      timeout_overflow_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      sl_reg <= sl_next;
      addr_ack <= take_any;
      slave_addressed <= (sl_next == TAC_SL_ADDRESSED);
      if (take_any)
        gcall_addressed <= gc_take;
      if (take_any)
        bus_state_code <= code_next;
      else if (to_ovf)
        bus_state_code <= `TAC_CODE_TIMEOUT;
      serial_event <= take_any || to_ovf;
      // set wins over a write-one clear
      stat_reg[`TAC_IRQ_EVENT] <= take_any ||
        (stat_reg[`TAC_IRQ_EVENT] && !(clr_wr && pwdata[`TAC_IRQ_EVENT]));
      stat_reg[`TAC_IRQ_TIMEOUT] <= to_ovf ||
        (stat_reg[`TAC_IRQ_TIMEOUT] && !(clr_wr && pwdata[`TAC_IRQ_TIMEOUT]));
      timeout_overflow_flag <= timeout_control_reg[`TAC_TOC_FLAG];
      irq <= |(stat_reg & mask_reg);
    end
  end

  // cycles since the last tick; armed from the first tick as master, cleared by a divisor write or leaving master mode
  wire rate_wr = acc_wr && hit_rate;
  logic [9:0] gap_reg;
  logic gap_armed_reg;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      gap_reg <= 10'h000;
      gap_armed_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= scl_tick ? 10'h000 : gap_reg + 10'h001;
      gap_armed_reg <= master_mode && !rate_wr && (gap_armed_reg || scl_tick);
    end
  end

  addr_match_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (byte_done && sl_reg == TAC_SL_WAIT && !master_mode && acknowledge_enable &&
     rx_byte[7:1] == own_slave_address_reg[7:1]) |=> addr_ack && slave_addressed)
    else $error("own address match not acknowledged");
  ack_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !acknowledge_enable |=> !addr_ack)
    else $error("acknowledged without acknowledge enable");
  master_ignore_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    master_mode |=> !addr_ack)
    else $error("address acknowledged in master mode");
  gcall_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (byte_done && rx_byte == 8'h00 && !general_call_enable &&
     own_slave_address_reg[7:1] != 7'h00) |=> !addr_ack)
    else $error("general call taken while disabled");
  gc_master_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (master_mode && general_call_enable) |=> !gcall_addressed || $stable(gcall_addressed))
    else $error("general call acted in master mode");
  sequence rate_quiet_s;
    !scl_tick [*3];
  endsequence
  rate_period_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (scl_tick && master_mode && bit_rate_divisor_reg == 8'h03 && $stable(master_mode)) |=>
    rate_quiet_s)
    else $error("serial clock tick too early");
  slave_rate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !master_mode |=> ##1 !scl_tick)
    else $error("rate divider ran in slave mode");
  to_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!timeout_counter_enable [*2]) |-> !to_ovf)
    else $error("time-out overflow while disabled");
  to_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (timeout_control_reg[0] && !to_clr) |=> timeout_control_reg[0])
    else $error("time-out flag lost without clear");
  to_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    to_ovf |=> timeout_control_reg[0] ##1 timeout_overflow_flag)
    else $error("time-out flag not set on overflow");
  event_code_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    serial_event |-> bus_state_code != `TAC_CODE_IDLE)
    else $error("event raised with idle code");
  rate_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (scl_tick && gap_armed_reg) |-> gap_reg == ({2'b00, bit_rate_divisor_reg} << 2) + 10'h003)
    else $error("serial clock period off");
  sequence ev_raise_s;
    serial_event && stat_reg[`TAC_IRQ_EVENT];
  endsequence
  addr_event_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_any |=> ev_raise_s)
    else $error("address event not flagged");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|(stat_reg & mask_reg)) |=> irq)
    else $error("interrupt missing for unmasked status");
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(|(stat_reg & mask_reg)) |=> !irq)
    else $error("interrupt without unmasked status");
  gcall_code_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    gc_take |=> gcall_addressed && bus_state_code == `TAC_CODE_GCALL)
    else $error("general call not reported");
  to_code_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (to_ovf && !take_any) |=> bus_state_code == `TAC_CODE_TIMEOUT && serial_event)
    else $error("time-out state not reported");
  toc_upper_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (setup && !pwrite && hit_toc) |=> prdata[31:3] == 29'h00000000)
    else $error("time-out control upper bits not zero");
  apb_ready_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    setup |=> pready)
    else $error("no ready in the access cycle");
  apb_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    pready |=> !pready)
    else $error("ready held past one cycle");
  apb_err_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (setup && !hit_any) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  master_free_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    master_mode |=> !slave_addressed)
    else $error("addressed as slave in master mode");
  own_miss_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (first_byte && rx_byte[7:1] != own_slave_address_reg[7:1] && !gc_match) |=> !addr_ack)
    else $error("foreign address acknowledged");
  no_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (own_match && !acknowledge_enable) |=> !slave_addressed)
    else $error("addressed without acknowledge enable");
  rate_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rate_wr |=> bit_rate_divisor_reg == $past(pwdata[7:0]))
    else $error("divisor write lost");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (to_clr && !to_ovf) |=> !timeout_control_reg[`TAC_TOC_FLAG])
    else $error("time-out flag not cleared by software");
endmodule // tac_config

//--- test/tac_bus_model.sv
// far-side two-wire master: a start, then one address byte
`timescale 1ns/1ps
module tac_bus_model
(
  input wire logic clk_sys,
  input wire logic go,
  input wire tac_pkg::tac_byte_t byte_in,
  output logic start_seen,
  output logic byte_done,
  output logic bus_activity,
  output tac_pkg::tac_byte_t rx_byte
);
  import tac_pkg::*;
  initial
  begin
    start_seen = 1'b0;
    byte_done = 1'b0;
    bus_activity = 1'b0;
    rx_byte = 8'h00;
  end
  always @(posedge clk_sys)
  begin
    start_seen <= go;
    bus_activity <= go;
    byte_done <= start_seen;
    // byte only valid with byte_done; otherwise it keeps changing
    rx_byte <= start_seen ? byte_in : ~rx_byte;
  end
endmodule // tac_bus_model

//--- test/tac_config_tb_top.sv
// self-checking bench for the two-wire configuration block
`timescale 1ns/1ps
`include "tac_defines.svh"
module tac_config_tb_top;
  import tac_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, master_mode, acknowledge_enable, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, start_seen, byte_done, bus_activity, addr_ack, slave_addressed;
  logic gcall_addressed, scl_tick, serial_event, timeout_overflow_flag, irq;
  logic [4:0] bus_state_code;
  tac_byte_t rx_byte, byte_in;
  int num_errors, checked, n;
  tac_config DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .master_mode(master_mode), .acknowledge_enable(acknowledge_enable),
    .start_seen(start_seen), .byte_done(byte_done), .rx_byte(rx_byte),
    .bus_activity(bus_activity), .addr_ack(addr_ack), .slave_addressed(slave_addressed),
    .gcall_addressed(gcall_addressed), .scl_tick(scl_tick), .bus_state_code(bus_state_code),
    .serial_event(serial_event), .timeout_overflow_flag(timeout_overflow_flag), .irq(irq));
  tac_bus_model far_end (.clk_sys(clk_sys), .go(go), .byte_in(byte_in),
    .start_seen(start_seen), .byte_done(byte_done), .bus_activity(bus_activity),
    .rx_byte(rx_byte));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task give_verdict;
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      chk(0, 1);
      give_verdict();
    end
  endtask
  // one start plus address byte; collects acknowledge and event pulses
  task addr_try(input tac_byte_t b, input logic ack_exp, input logic [4:0] code_exp);
    logic got;
    logic ev;
    got = 1'b0;
    ev = 1'b0;
    @(posedge clk_sys);
    byte_in <= b;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (6)
    begin
      @(posedge clk_sys);
      #1;
      got = got | addr_ack;
      ev = ev | serial_event;
    end
    chk(got, ack_exp);
    chk(ev, ack_exp);
    if (ack_exp)
      chk(bus_state_code, code_exp);
    chk(slave_addressed, ack_exp);
    @(posedge clk_sys);
  endtask
  task t_regs;
    apb(0, `TAC_OFF_RATE, 0);
    chk(rd, 32'h09);
    apb(0, `TAC_OFF_TOC, 0);
    chk(rd, 32'h01);
    apb(0, `TAC_OFF_ADDR, 0);
    chk(rd, 32'h00);
    apb(0, 12'h400, 0);
    chk(er, 1'b1);
    apb(1, `TAC_OFF_TOC, 32'hf8);
    apb(0, `TAC_OFF_TOC, 0);
    chk(rd, 32'h00);
  endtask
  task t_addr;
    apb(1, `TAC_OFF_ADDR, 32'h54);
    acknowledge_enable <= 1'b1;
    addr_try(8'h54, 1, `TAC_CODE_OWN_WR);
    addr_try(8'h55, 1, `TAC_CODE_OWN_RD);
    addr_try(8'h56, 0, 0);
    addr_try(8'hd4, 0, 0);
    acknowledge_enable <= 1'b0;
    addr_try(8'h54, 0, 0);
    acknowledge_enable <= 1'b1;
    addr_try(8'h00, 0, 0);
    apb(1, `TAC_OFF_ADDR, 32'h55);
    addr_try(8'h00, 1, `TAC_CODE_GCALL);
    chk(gcall_addressed, 1'b1);
    acknowledge_enable <= 1'b0;
    addr_try(8'h00, 0, 0);
    master_mode <= 1'b1;
    acknowledge_enable <= 1'b1;
    addr_try(8'h54, 0, 0);
    addr_try(8'h00, 0, 0);
    master_mode <= 1'b0;
    apb(0, `TAC_OFF_STAT, 0);
    chk(rd[0], 1'b1);
    apb(1, `TAC_OFF_STAT, 32'h3);
  endtask
  task t_rate;
    apb(1, `TAC_OFF_RATE, 32'h03);
    master_mode <= 1'b1;
    for (n = 0; n < 100 && scl_tick !== 1'b1; n++)
      @(posedge clk_sys) #1;
    chk(n < 100, 1);
    for (n = 1; n < 100; n++)
    begin
      @(posedge clk_sys) #1;
      if (scl_tick === 1'b1)
        break;
    end
    chk(n, 16);
    @(posedge clk_sys);
    master_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (n = 0; n < 64 && scl_tick !== 1'b1; n++)
      @(posedge clk_sys) #1;
    chk(n, 64);
  endtask
  task t_timeout;
    repeat (17000) @(posedge clk_sys);
    apb(0, `TAC_OFF_TOC, 0);
    chk(rd, 32'h00);
    apb(1, `TAC_OFF_TOC, 32'h06);
    repeat (17000) @(posedge clk_sys);
    apb(0, `TAC_OFF_TOC, 0);
    chk(rd, 32'h06);
    apb(1, `TAC_OFF_TOC, 32'h00);
    apb(1, `TAC_OFF_IMASK, 32'h2);
    apb(1, `TAC_OFF_TOC, 32'h04);
    for (n = 0; n < 17000 && timeout_overflow_flag !== 1'b1; n++)
      @(posedge clk_sys) #1;
    chk(n >= 16380 && n <= 16395, 1);
    chk(bus_state_code, `TAC_CODE_TIMEOUT);
    chk(irq, 1'b1);
    apb(1, `TAC_OFF_TOC, 32'h00);
    repeat (200) @(posedge clk_sys);
    apb(0, `TAC_OFF_TOC, 0);
    chk(rd, 32'h00);
    apb(0, `TAC_OFF_STAT, 0);
    chk(rd[1:0], 2'b10);
    apb(1, `TAC_OFF_IMASK, 32'h0);
    @(posedge clk_sys) #1;
    chk(irq, 1'b0);
    apb(1, `TAC_OFF_STAT, 32'h3);
    apb(0, `TAC_OFF_STAT, 0);
    chk(rd, 32'h0);
  endtask
  initial
  begin
    num_errors = 0;
    checked = 0;
    nrst = 1'b0;
    {psel, penable, pwrite, master_mode, acknowledge_enable, go} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    byte_in = 8'h00;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_addr();
    t_rate();
    t_timeout();
    give_verdict();
  end
endmodule // tac_config_tb_top
